/* rtl/dfs_pkg.sv */
// package for the drive fault supervisor: fault codes, widths, reset values, counts
// assumes a single 200 MHz system clock domain
package dfs_pkg;

	// fault codes (decimal display numbers)
	localparam logic [7:0] FC_NONE       = 8'h00;
	localparam logic [7:0] FC_SUPPLY_TAG = 8'h01;
	localparam logic [7:0] FC_SUPPLY0    = 8'h19;
	localparam logic [7:0] FC_CHARGE     = 8'h1c;
	localparam logic [7:0] FC_MAINS      = 8'h1d;
	localparam logic [7:0] FC_I2T        = 8'h1e;
	localparam logic [7:0] FC_OVERLOAD   = 8'h1f;
	localparam logic [7:0] FC_ASYM       = 8'h26;
	localparam logic [7:0] FC_COMMUT     = 8'h27;
	localparam logic [7:0] FC_ENC2       = 8'h2a;
	localparam logic [7:0] FC_CYCLIC     = 8'h2b;
	localparam logic [7:0] FC_ERR_PASV   = 8'h2c;
	localparam logic [7:0] FC_BUS_OFF    = 8'h2d;

	// fault bit positions
	localparam int NUM_FAULTS   = 13;
	localparam int FB_SUP0      = 0;
	localparam int FB_SUP2      = 2;
	localparam int FB_CHARGE    = 3;
	localparam int FB_MAINS     = 4;
	localparam int FB_I2T       = 5;
	localparam int FB_OVERLOAD  = 6;
	localparam int FB_ASYM      = 7;
	localparam int FB_COMMUT    = 8;
	localparam int FB_ENC2      = 9;
	localparam int FB_CYCLIC    = 10;
	localparam int FB_ERR_PASV  = 11;
	localparam int FB_BUS_OFF   = 12;

	// bits 0..9 cut power, 10..12 use the emergency ramp
	localparam logic [12:0] DISABLE_MASK = 13'h03ff;
	localparam logic [12:0] RAMP_MASK    = 13'h1c00;
	localparam logic [12:0] FAULT_RST    = 13'h0000;

	// bus error counter thresholds
	localparam logic [7:0] CAN_PASV_LIMIT = 8'h7f;
	localparam logic [7:0] CAN_OFF_LIMIT  = 8'hff;
	localparam logic [7:0] LOST_RST       = 8'h00;

	// alarm dot blink: 250 ms half period at 200 MHz
	localparam int          CLK_MHZ        = 200;
	localparam int          BLINK_HALF_MS  = 250;
	localparam int          BLINK_CYCLES   = BLINK_HALF_MS * 1000 * CLK_MHZ;
	localparam logic [27:0] BLINK_RST      = 28'h0000000;

	typedef struct packed {
		logic [2:0] supply_low;
		logic       charge_defect;
		logic       mains_over;
		logic       i2t_over;
		logic       overload_over;
		logic       enc_asym;
		logic       commut_fail;
		logic       enc2_break;
		logic       enc2_init_fail;
	} dfs_cond_s;

	typedef struct packed {
		logic       power_disable;
		logic       emergency_ramp;
		logic [7:0] code;
		logic       supply_tag;
	} dfs_resp_s;

endpackage : dfs_pkg

/* rtl/dfs_supervisor.sv */
// drive fault supervisor: latches faults, chooses response, drives alarm dot
// assumes condition, option and alarm inputs are asynchronous levels
// assumes ack and bus counters come from logic on i_clk_sys
//
// Functional notes
// - supply undervoltage: codes 25-27 plus 01, disable
// - charging circuit defect: code 28, disable
// - mains power high: code 29, disable, acknowledgeable
// - motor i2t loss high: code 30, disable
// - overload protection limit: code 31, disable
// - encoder track amplitude mismatch: code 38, disable
// - commutation measurement unfinished: code 39, disable
// - second encoder break/init fail: code 42
// - lost cyclic data maximum: code 43, ramp
// - bus counter >127 code 44; 255 also sets the code 45 flag, but code 44 is shown
// - pending alarm flashes display decimal point
`timescale 1ns/1ps

module dfs_supervisor #(
	parameter int BLINK_CYCLES = dfs_pkg::BLINK_CYCLES
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset,
	input  wire dfs_pkg::dfs_cond_s i_cond,
	input  wire logic              i_second_encoder_option,
	input  wire logic [7:0]        i_lost_count,
	input  wire logic [7:0]        i_lost_max,
	input  wire logic [7:0]        i_can_err_count,
	input  wire logic              i_ack,
	input  wire logic              i_alarm_pending,
	output logic [12:0]            o_fault_flags,
	output dfs_pkg::dfs_resp_s     o_resp,
	output logic                   o_display_dot
);

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [10:0] sync1_ff;
	logic [10:0] sync2_ff;
	logic [10:0] nxt_sync1;
	logic [10:0] nxt_sync2;
	logic        opt1_ff;
	logic        opt2_ff;
	logic        nxt_opt1;
	logic        nxt_opt2;
	logic        alm1_ff;
	logic        alm2_ff;
	logic        nxt_alm1;
	logic        nxt_alm2;

	// condition levels: only the second stage reads the first
	always_comb begin
		nxt_sync1 = i_cond;
		nxt_sync2 = sync1_ff;
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			sync1_ff <= 11'h000;
			sync2_ff <= 11'h000;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end

	// ****************************************
	// second encoder option strap
	// ****************************************
	always_comb begin
		nxt_opt1 = i_second_encoder_option;
		nxt_opt2 = opt1_ff;
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			opt1_ff <= 1'b0;
			opt2_ff <= 1'b0;
		end else begin
			opt1_ff <= nxt_opt1;
			opt2_ff <= nxt_opt2;
		end
	end

	// ****************************************
	// alarm pending level
	// ****************************************
	always_comb begin
		nxt_alm1 = i_alarm_pending;
		nxt_alm2 = alm1_ff;
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			alm1_ff <= 1'b0;
			alm2_ff <= 1'b0;
		end else begin
			alm1_ff <= nxt_alm1;
			alm2_ff <= nxt_alm2;
		end
	end

	dfs_pkg::dfs_cond_s cond;
	assign cond = sync2_ff;

	// ****************************************
	// bus counter thresholds, same clock, no sync
	// ****************************************
	logic lost_hit;
	logic pasv_hit;
	logic off_hit;

	// zero max switches the lost-data check off; at 255 both bus faults stand
	always_comb begin
		lost_hit = (i_lost_max != dfs_pkg::LOST_RST) && (i_lost_count >= i_lost_max);
		pasv_hit = i_can_err_count > dfs_pkg::CAN_PASV_LIMIT;
		off_hit  = i_can_err_count == dfs_pkg::CAN_OFF_LIMIT;
	end

	// ****************************************
	// raw fault conditions
	// ****************************************
	logic [12:0] raw;

	always_comb begin
		raw                       = dfs_pkg::FAULT_RST;
		// supply and power stage
		raw[dfs_pkg::FB_SUP2:dfs_pkg::FB_SUP0] = cond.supply_low;
		raw[dfs_pkg::FB_CHARGE]   = cond.charge_defect;
		raw[dfs_pkg::FB_MAINS]    = cond.mains_over;
		raw[dfs_pkg::FB_I2T]      = cond.i2t_over;
		raw[dfs_pkg::FB_OVERLOAD] = cond.overload_over;

		// encoders; the second one only counts when fitted
		raw[dfs_pkg::FB_ASYM]     = cond.enc_asym;
		raw[dfs_pkg::FB_COMMUT]   = cond.commut_fail;
		raw[dfs_pkg::FB_ENC2]     = opt2_ff & (cond.enc2_break | cond.enc2_init_fail);

		// communication
		raw[dfs_pkg::FB_CYCLIC]   = lost_hit;
		raw[dfs_pkg::FB_ERR_PASV] = pasv_hit;
		raw[dfs_pkg::FB_BUS_OFF]  = off_hit;
	end

	// ****************************************
	// fault latch: set wins, clear needs ack and cleared cause
	// ****************************************
	logic [12:0] fault_ff;
	logic [12:0] nxt_fault;

	// per bit: a live cause always wins over ack
	always_comb begin
		nxt_fault = fault_ff;
		for (int b = 0; b < dfs_pkg::NUM_FAULTS; b++) begin
			if (raw[b]) begin
				nxt_fault[b] = 1'b1;
			end else if (i_ack) begin
				nxt_fault[b] = 1'b0;
			end else begin
				nxt_fault[b] = fault_ff[b];
			end
		end
	end

	// ****************************************
	// fault latch register
	// ****************************************

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			fault_ff <= dfs_pkg::FAULT_RST;
		end else begin
			fault_ff <= nxt_fault;
		end
	end

	// ****************************************
	// response and reported code
	// ****************************************
	// index of the lowest-numbered latched fault, 4'hf if none
	function automatic logic [3:0] first_fault(input logic [12:0] f);
		logic [3:0] idx;
		idx = 4'hf;
		for (int i = dfs_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
			if (f[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : first_fault

	// ****************************************
	// display code table
	// ****************************************
	// unused indices mean no fault
	function automatic logic [7:0] fault_code(input logic [3:0] idx);
		logic [7:0] c;
		unique case (idx)
			4'h0:    c = dfs_pkg::FC_SUPPLY0;
			4'h1:    c = dfs_pkg::FC_SUPPLY0 + 8'h01;
			4'h2:    c = dfs_pkg::FC_SUPPLY0 + 8'h02;
			4'h3:    c = dfs_pkg::FC_CHARGE;
			4'h4:    c = dfs_pkg::FC_MAINS;
			4'h5:    c = dfs_pkg::FC_I2T;
			4'h6:    c = dfs_pkg::FC_OVERLOAD;
			4'h7:    c = dfs_pkg::FC_ASYM;
			4'h8:    c = dfs_pkg::FC_COMMUT;
			4'h9:    c = dfs_pkg::FC_ENC2;
			4'ha:    c = dfs_pkg::FC_CYCLIC;
			4'hb:    c = dfs_pkg::FC_ERR_PASV;
			4'hc:    c = dfs_pkg::FC_BUS_OFF;
			default: c = dfs_pkg::FC_NONE;
		endcase
		return c;
	endfunction : fault_code

	// ****************************************
	// response registers
	// ****************************************

	dfs_pkg::dfs_resp_s resp_ff;
	dfs_pkg::dfs_resp_s nxt_resp;
	logic               dis_any;
	logic               ramp_any;
	logic               sup_any;

	// registered so the response lags the flags by one cycle
	always_comb begin
		dis_any                 = |(fault_ff & dfs_pkg::DISABLE_MASK);
		ramp_any                = |(fault_ff & dfs_pkg::RAMP_MASK);
		sup_any                 = |fault_ff[dfs_pkg::FB_SUP2:dfs_pkg::FB_SUP0];
		nxt_resp.power_disable  = dis_any;
		nxt_resp.emergency_ramp = ramp_any & ~dis_any;
		nxt_resp.code           = fault_code(first_fault(fault_ff));
		nxt_resp.supply_tag     = sup_any;
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			resp_ff <= '0;
		end else begin
			resp_ff <= nxt_resp;
		end
	end

	// ****************************************
	// alarm dot blink
	// ****************************************
	logic [27:0] blink_cnt_ff;
	logic [27:0] nxt_blink_cnt;
	logic        blink_wrap;
	logic        dot_ff;
	logic        nxt_dot;

	// half-period counter, held at zero while nothing is pending
	always_comb begin
		blink_wrap    = blink_cnt_ff >= 28'(BLINK_CYCLES - 1);
		nxt_blink_cnt = blink_cnt_ff + 28'h0000001;
		if (!alm2_ff || blink_wrap) begin
			nxt_blink_cnt = dfs_pkg::BLINK_RST;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			blink_cnt_ff <= dfs_pkg::BLINK_RST;
		end else begin
			blink_cnt_ff <= nxt_blink_cnt;
		end
	end

	// ****************************************
	// alarm dot output
	// ****************************************
	// toggles at each wrap, dark when idle
	always_comb begin
		nxt_dot = dot_ff;
		if (!alm2_ff) begin
			nxt_dot = 1'b0;
		end else if (blink_wrap) begin
			nxt_dot = ~dot_ff;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			dot_ff <= 1'b0;
		end else begin
			dot_ff <= nxt_dot;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// all straight from flip-flops
	assign o_fault_flags = fault_ff;
	assign o_resp        = resp_ff;
	assign o_display_dot = dot_ff;

endmodule : dfs_supervisor

/* sim/dfs_sup_props.sv */
// checker for the fault supervisor ports
// assumes it is bound onto dfs_supervisor
`timescale 1ns/1ps
module dfs_sup_props (
	input wire logic               i_clk_sys,
	input wire logic               i_reset,
	input wire dfs_pkg::dfs_cond_s i_cond,
	input wire logic [7:0]         i_lost_count,
	input wire logic [7:0]         i_lost_max,
	input wire logic [7:0]         i_can_err_count,
	input wire logic               i_ack,
	input wire logic [12:0]        o_fault_flags,
	input wire dfs_pkg::dfs_resp_s o_resp
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	sequence s_chg_up; i_cond.charge_defect[*3]; endsequence
	sequence s_chg_acked; (!i_cond.charge_defect)[*3] ##0 i_ack; endsequence
	a_charge_set: assert property (s_chg_up |=> o_fault_flags[3])
		else $error("charge flag missing");
	a_flag_hold: assert property (o_fault_flags[3] && !i_ack |=> o_fault_flags[3])
		else $error("flag dropped without ack");
	a_ack_clear: assert property (s_chg_acked |=> !o_fault_flags[3])
		else $error("flag kept after ack");
	a_bus_off: assert property (i_can_err_count == 8'hff |=> o_fault_flags[12] && o_fault_flags[11])
		else $error("bus off missing");
	a_err_passive: assert property (i_can_err_count > 8'h7f |=> o_fault_flags[11])
		else $error("passive missing");
	a_lost_max: assert property (i_lost_max != 8'h00 && i_lost_count >= i_lost_max |=> o_fault_flags[10])
		else $error("lost data fault missing");
	a_disable_resp: assert property (o_resp.power_disable == |($past(o_fault_flags) & dfs_pkg::DISABLE_MASK))
		else $error("power disable wrong");
	a_ramp_loses: assert property (o_resp.emergency_ramp == (|($past(o_fault_flags) & dfs_pkg::RAMP_MASK)
		&& !(|($past(o_fault_flags) & dfs_pkg::DISABLE_MASK)))) else $error("ramp wrong");
	a_supply_tag: assert property (o_resp.supply_tag == |$past(o_fault_flags[2:0]))
		else $error("supply tag wrong");
endmodule : dfs_sup_props

bind dfs_supervisor dfs_sup_props u_props (.i_clk_sys, .i_reset, .i_cond, .i_lost_count, .i_lost_max,
	.i_can_err_count, .i_ack, .o_fault_flags, .o_resp);

/* sim/dfs_host_model.sv */
// host controller model: acknowledges faults on request
// assumes the bench raises i_req on the system clock
`timescale 1ns/1ps
module dfs_host_model (
	input  wire logic i_clk_sys,
	input  wire logic i_req,
	output logic      o_ack
);
	always_ff @(posedge i_clk_sys) begin
		o_ack <= i_req;
	end
endmodule : dfs_host_model

/* sim/tb.sv */
// self-checking bench for the drive fault supervisor
// assumes dfs_pkg, the checker and the host model compiled first
`timescale 1ns/1ps
module tb;
	logic               clk  = 1'b0;
	logic               rst  = 1'b1;
	logic               opt  = 1'b1;
	logic               req  = 1'b0;
	logic               pend = 1'b0;
	logic               ack;
	logic               dot;
	logic               hi;
	logic               lo;
	logic [7:0]         lcnt = 8'h00;
	logic [7:0]         lmax = 8'h00;
	logic [7:0]         ccnt = 8'h00;
	logic [12:0]        flg;
	dfs_pkg::dfs_cond_s cond = '0;
	dfs_pkg::dfs_resp_s rsp;
	int                 error_cnt  = 0;
	int                 n_compared = 0;
	localparam logic [7:0] CODES [10] = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h26, 8'h27, 8'h2a};
	always #2.5 clk = ~clk;
	dfs_host_model u_host (.i_clk_sys(clk), .i_req(req), .o_ack(ack));
	dfs_supervisor #(.BLINK_CYCLES(4)) dut (.i_clk_sys(clk), .i_reset(rst), .i_cond(cond),
		.i_second_encoder_option(opt), .i_lost_count(lcnt), .i_lost_max(lmax), .i_can_err_count(ccnt),
		.i_ack(ack), .i_alarm_pending(pend), .o_fault_flags(flg), .o_resp(rsp), .o_display_dot(dot));
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic clr();
		@(posedge clk);
		cond <= '0;
		lcnt <= 8'h00;
		ccnt <= 8'h00;
		req  <= 1'b1;
		cyc(6);
		@(posedge clk);
		req <= 1'b0;
		cyc(2);
		chk({2'b00, rsp}, 13'h0000);
	endtask : clr
	task automatic t_disable();
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			cond <= dfs_pkg::dfs_cond_s'(i < 3 ? 11'h100 << i : i < 9 ? 11'h400 >> i : 11'h002);
			cyc(5);
			chk(flg, 13'h0001 << i); // to
			chk({2'b00, rsp}, {4'h2, CODES[i], i < 3}); // to
			@(posedge clk);
			req <= 1'b1;
			cyc(3);
			chk(flg, 13'h0001 << i);
			clr();
		end
	endtask : t_disable
	task automatic t_option();
		@(posedge clk);
		opt  <= 1'b0;
		cond <= dfs_pkg::dfs_cond_s'(11'h002);
		cyc(5);
		chk(flg, 13'h0000);
		@(posedge clk);
		opt  <= 1'b1;
		cond <= dfs_pkg::dfs_cond_s'(11'h001);
		cyc(5);
		chk(flg, 13'h0200);
		clr();
	endtask : t_option
	task automatic t_bus();
		@(posedge clk);
		ccnt <= 8'h7f;
		cyc(3);
		chk(flg, 13'h0000);
		@(posedge clk);
		ccnt <= 8'h80;
		cyc(3);
		chk({2'b00, rsp}, {4'h1, 8'h2c, 1'b0});
		@(posedge clk);
		ccnt <= 8'hff;
		lmax <= 8'h05;
		lcnt <= 8'h04;
		cyc(3);
		chk(flg, 13'h1800);
		@(posedge clk);
		lcnt <= 8'h05;
		cyc(3);
		chk({2'b00, rsp}, {4'h1, 8'h2b, 1'b0});
		@(posedge clk);
		cond <= dfs_pkg::dfs_cond_s'(11'h080);
		cyc(5);
		chk({2'b00, rsp}, {4'h2, 8'h1c, 1'b0});
		clr();
	endtask : t_bus
	task automatic t_dot();
		hi = 1'b0;
		lo = 1'b0;
		@(posedge clk);
		pend <= 1'b1;
		cyc(4);
		for (int k = 0; k < 16; k++) begin
			cyc(1);
			hi = hi | (dot === 1'b1);
			lo = lo | (dot === 1'b0);
		end
		chk({12'h000, hi & lo}, 13'h0001);
		@(posedge clk);
		pend <= 1'b0;
		cyc(12);
		chk({12'h000, dot}, 13'h0000);
	endtask : t_dot
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		cyc(2);
		t_disable();
		t_option();
		t_bus();
		t_dot();
		complete_run();
	end
endmodule : tb
